// ### rtl/ocm_pkg.sv
/*
  Constants for the output compare channel: register map, field
  positions, reset values and mode codes.
  Assumes a 16-bit register port with one-cycle read latency.
*/
// Behaviour
// R1: Trigger-status mode 1: secondary match clears flag
// R2: Trigger-status mode 0: only software clears flag
// R3: Mode 111: high on primary, low on secondary
// R4: Mode 110: high at zero, low on primary
// R5: Mode 101: start low, toggle each alternate match
// R6: Mode 100: start low, one pulse only
// R7: Mode 011: toggle and event every primary match
// R8: Mode 010: start high, low on first match
// R9: Mode 001: start low, high on first match
// R10: Mode 000: channel disabled, no activity
// R11: Compare values double-buffered only in PWM modes
// R12: One trigger-generator clock source per channel
// R13: Trigger status flag at control-two bit 6
// R14: Mode bits 2..0, trigger mode bit 3
// R15: PWM buffers load at timer period end
package ocm_pkg;
  // ---------------------------------------------------------------
  // Register map (word indices on the register port)
  // ---------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL_ONE   = 4'h0;
  localparam logic [3:0]  ADDR_CTRL_TWO   = 4'h1;
  localparam logic [3:0]  ADDR_PRIMARY    = 4'h2;
  localparam logic [3:0]  ADDR_SECONDARY  = 4'h3;
  localparam logic [3:0]  ADDR_PERIOD     = 4'h4;
  localparam logic [3:0]  ADDR_TIMER      = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h7;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int          MODE_LSB        = 0;
  localparam int          MODE_MSB        = 2;
  localparam int          TRIG_MODE_BIT   = 3;
  localparam int          TRIG_STAT_BIT   = 6;
  localparam int          IRQ_CMP_BIT     = 0;
  localparam int          IRQ_SEC_BIT     = 1;
  localparam int          IRQ_PERIOD_BIT  = 2;
  localparam int          IRQ_WIDTH       = 3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_CTRL        = 16'h0000;
  localparam logic [15:0] RST_VALUE       = 16'h0000;
  localparam logic [15:0] RST_PERIOD      = 16'hFFFF;
  localparam logic [15:0] TIMER_ZERO      = 16'h0000;
  localparam logic [15:0] TIMER_STEP      = 16'h0001;
  // ---------------------------------------------------------------
  // Mode codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_SS_HIGH  = 3'h1,
    MODE_SS_LOW   = 3'h2,
    MODE_TOGGLE   = 3'h3,
    MODE_DC_SHOT  = 3'h4,
    MODE_DC_CONT  = 3'h5,
    MODE_PWM_EDGE = 3'h6,
    MODE_PWM_CTR  = 3'h7
  } ocm_mode_t;
endpackage

// ### rtl/ocm_channel.sv
/*
  One output compare channel: free-running channel timer, primary and
  secondary compare values, mode logic, trigger status and interrupt.
  Assumes synchronous register port strobes, never both at once.
  Pin level and trigger pulse leave the block registered.
*/
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
module ocm_channel
  import ocm_pkg::*;
(
  input  wire logic        i_core_clk,    // Core clock, 100 MHz
  input  wire logic        i_sys_rst,     // Synchronous reset, high
  input  wire logic [3:0]  i_addr,        // Register index
  input  wire logic [15:0] i_wdata,       // Write data
  input  wire logic        i_wr,          // Write strobe
  input  wire logic        i_rd,          // Read strobe
  output logic      [15:0] o_rdata,       // Read data, cycle after strobe
  output logic             o_compare_out, // Compare output pin
  output logic             o_trig_clk,    // Trigger generator clock pulse
  output logic             o_irq          // Interrupt, level
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Registered state
  logic [15:0]          ctrl_one;
  logic                 trig_status_flag;
  logic [15:0]          pri_buf;
  logic [15:0]          sec_buf;
  logic [15:0]          pri_act;
  logic [15:0]          sec_act;
  logic [15:0]          period;
  logic [15:0]          channel_timer;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic                 shot_done;
  logic                 dc_phase;
  logic [2:0]           mode_prev;
  // Decoded and next-state signals
  ocm_mode_t            mode;
  logic                 is_pwm;
  logic                 pri_hit;
  logic                 sec_hit;
  logic                 zero_hit;
  logic                 period_end;
  logic                 mode_chg;
  logic                 cmp_event;
  logic                 next_out;
  logic                 next_shot_done;
  logic                 next_dc_phase;
  logic [IRQ_WIDTH-1:0] irq_set;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Mode field and match detection
  assign mode       = ocm_mode_t'(ctrl_one[MODE_MSB:MODE_LSB]);        // [R14]
  assign is_pwm     = (mode == MODE_PWM_EDGE) || (mode == MODE_PWM_CTR);
  assign pri_hit    = (channel_timer == pri_act);
  assign sec_hit    = (channel_timer == sec_act);
  assign zero_hit   = (channel_timer == TIMER_ZERO);
  assign period_end = (channel_timer == period);
  assign mode_chg   = (mode_prev != ctrl_one[MODE_MSB:MODE_LSB]);

  // ---------------------------------------------------------------
  // Control and compare registers
  // ---------------------------------------------------------------
  // Control one and period written by software
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_one <= RST_CTRL;
      period   <= RST_PERIOD;
    end else if (i_wr) begin
      if (i_addr == ADDR_CTRL_ONE) begin
        ctrl_one <= i_wdata;
      end
      if (i_addr == ADDR_PERIOD) begin
        period <= i_wdata;
      end
    end
  end

  // Software-visible compare values
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pri_buf <= RST_VALUE;
      sec_buf <= RST_VALUE;
    end else if (i_wr) begin
      if (i_addr == ADDR_PRIMARY) begin
        pri_buf <= i_wdata;
      end
      if (i_addr == ADDR_SECONDARY) begin
        sec_buf <= i_wdata;
      end
    end
  end

  // Active compare values: direct outside PWM, period-end load in PWM
  // Load on mode entry so a PWM run never starts from a stale pair
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pri_act <= RST_VALUE;
      sec_act <= RST_VALUE;
    end else if (!is_pwm || period_end || mode_chg) begin // [R11] [R15]
      pri_act <= pri_buf;
      sec_act <= sec_buf;
    end
  end

  // ---------------------------------------------------------------
  // Channel timer
  // ---------------------------------------------------------------
  // Free-running up counter, wraps at period, cleared while disabled
  // One period spans period plus one clocks
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || mode == MODE_OFF) begin
      channel_timer <= TIMER_ZERO;
    end else if (period_end) begin
      channel_timer <= TIMER_ZERO;
    end else begin
      channel_timer <= channel_timer + TIMER_STEP;
    end
  end

  // ---------------------------------------------------------------
  // Output mode logic
  // ---------------------------------------------------------------
  // Next pin level, one-shot and double-compare phase
  always_comb begin
    next_out       = o_compare_out;
    next_shot_done = shot_done;
    next_dc_phase  = dc_phase;
    cmp_event      = 1'b0;
    // Mode entry wins over any match in the same cycle
    if (mode_chg) begin
      next_shot_done = 1'b0;
      next_dc_phase  = 1'b0;
      next_out       = (mode == MODE_SS_LOW);                 // [R8] [R9] [R5] [R6]
    end else begin
      unique case (mode)
        MODE_OFF: begin
          next_out = 1'b0;                                    // [R10]
        end
        MODE_SS_HIGH: begin
          if (pri_hit && !shot_done) begin
            next_out       = 1'b1;                            // [R9]
            next_shot_done = 1'b1;
            cmp_event      = 1'b1;
          end
        end
        MODE_SS_LOW: begin
          if (pri_hit && !shot_done) begin
            next_out       = 1'b0;                            // [R8]
            next_shot_done = 1'b1;
            cmp_event      = 1'b1;
          end
        end
        MODE_TOGGLE: begin
          if (pri_hit) begin
            next_out  = !o_compare_out;                       // [R7]
            cmp_event = 1'b1;
          end
        end
        MODE_DC_SHOT: begin
          if (!shot_done && !dc_phase && pri_hit) begin
            next_out      = 1'b1;                             // [R6]
            next_dc_phase = 1'b1;
          end else if (!shot_done && dc_phase && sec_hit) begin
            next_out       = 1'b0;                            // [R6]
            next_shot_done = 1'b1;
            cmp_event      = 1'b1;
          end
        end
        MODE_DC_CONT: begin
          if (!dc_phase && pri_hit) begin
            next_out      = 1'b1;                             // [R5]
            next_dc_phase = 1'b1;
          end else if (dc_phase && sec_hit) begin
            next_out      = 1'b0;                             // [R5]
            next_dc_phase = 1'b0;
            cmp_event     = 1'b1;
          end
        end
        MODE_PWM_EDGE: begin
          if (pri_hit) begin
            next_out = 1'b0;                                  // [R4]
          end else if (zero_hit) begin
            next_out = 1'b1;                                  // [R4]
          end
          cmp_event = pri_hit;
        end
        MODE_PWM_CTR: begin
          if (sec_hit) begin
            next_out = 1'b0;                                  // [R3]
          end else if (pri_hit) begin
            next_out = 1'b1;                                  // [R3]
          end
          cmp_event = sec_hit;
        end
      endcase
    end
  end

  // Pin and sequencing state
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_compare_out <= 1'b0;
      shot_done     <= 1'b0;
      dc_phase      <= 1'b0;
      mode_prev     <= RST_CTRL[MODE_MSB:MODE_LSB];
    end else begin
      o_compare_out <= next_out;
      shot_done     <= next_shot_done;
      dc_phase      <= next_dc_phase;
      mode_prev     <= ctrl_one[MODE_MSB:MODE_LSB];
    end
  end

  // One trigger clock pulse per compare event
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_trig_clk <= 1'b0;
    end else begin
      o_trig_clk <= cmp_event;                                // [R12]
    end
  end

  // ---------------------------------------------------------------
  // Trigger status flag
  // ---------------------------------------------------------------
  // Set on compare event; set wins over any clear
  // Where set and clear share one match, the flag stays set
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      trig_status_flag <= 1'b0;
    end else if (cmp_event) begin
      trig_status_flag <= 1'b1;
    end else if (i_wr && i_addr == ADDR_CTRL_TWO) begin
      trig_status_flag <= i_wdata[TRIG_STAT_BIT];             // [R13] [R1] [R2]
    end else if (ctrl_one[TRIG_MODE_BIT] && sec_hit && mode != MODE_OFF) begin
      trig_status_flag <= 1'b0;                               // [R1]
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // Interrupt sources, timer matches gated off while disabled
  assign irq_set[IRQ_CMP_BIT]    = cmp_event;
  assign irq_set[IRQ_SEC_BIT]    = sec_hit && (mode != MODE_OFF);
  assign irq_set[IRQ_PERIOD_BIT] = period_end && (mode != MODE_OFF);

  // Sticky status, write one to clear, set wins
  // An event in the clearing cycle is never lost
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      if (i_wr && i_addr == ADDR_IRQ_STATUS) begin
        irq_status <= (irq_status & ~i_wdata[IRQ_WIDTH-1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      if (i_wr && i_addr == ADDR_IRQ_MASK) begin
        irq_mask <= i_wdata[IRQ_WIDTH-1:0];
      end
    end
  end

  // Level interrupt from registered status
  // Lags status and mask by one clock
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Read data one cycle after strobe, zero otherwise
  // Control two shows only the trigger status flag
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !i_rd) begin
      o_rdata <= 16'h0000;
    end else begin
      unique case (i_addr)
        ADDR_CTRL_ONE:   o_rdata <= ctrl_one;
        ADDR_CTRL_TWO:   o_rdata <= 16'(trig_status_flag) << TRIG_STAT_BIT;
        ADDR_PRIMARY:    o_rdata <= pri_buf;
        ADDR_SECONDARY:  o_rdata <= sec_buf;
        ADDR_PERIOD:     o_rdata <= period;
        ADDR_TIMER:      o_rdata <= channel_timer;
        ADDR_IRQ_STATUS: o_rdata <= {13'h0000, irq_status};
        ADDR_IRQ_MASK:   o_rdata <= {13'h0000, irq_mask};
        default:         o_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // ocm_channel

// ### tb/ocm_pin_sink.sv
/*
  Far-side model: the output pin and the trigger generator input.
  Assumes registered pin and trigger pulse from the channel.
*/
`timescale 1ns/100ps
module ocm_pin_sink (
  input  wire logic i_core_clk, // Core clock
  input  wire logic i_sys_rst,  // Synchronous reset, high
  input  wire logic i_pin,      // Compare output pin
  input  wire logic i_trig,     // Trigger generator clock source
  output int        o_hi,       // Cycles with pin high
  output int        o_tg,       // Pin transitions seen
  output int        o_pu        // Trigger pulses seen
);
  logic last;
  // Count pin level, edges and trigger clocks
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_hi <= 0;
      o_tg <= 0;
      o_pu <= 0;
      last <= 1'b0;
    end else begin
      o_hi <= o_hi + int'(i_pin);
      o_tg <= o_tg + int'(i_pin !== last);
      o_pu <= o_pu + int'(i_trig);
      last <= i_pin;
    end
  end
endmodule // ocm_pin_sink

// ### tb/ocm_channel_sva.sv
/*
  Port checker for the output compare channel, bound to its top.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module ocm_checker
  import ocm_pkg::*;
(
  input wire logic        i_core_clk,    // Core clock
  input wire logic        i_sys_rst,     // Reset
  input wire logic [3:0]  i_addr,        // Register index
  input wire logic [15:0] i_wdata,       // Write data
  input wire logic        i_wr,          // Write strobe
  input wire logic        i_rd,          // Read strobe
  input wire logic [15:0] o_rdata,       // Read data
  input wire logic        o_compare_out, // Pin
  input wire logic        o_trig_clk,    // Trigger clock
  input wire logic        o_irq          // Interrupt
);
  logic [2:0] mode_q;
  logic [3:0] age;
  logic       mask_zero;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Shadow of the mode field and cycles since its last write
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mode_q <= 3'h0;
      age    <= 4'h0;
    end else if (i_wr && i_addr == ADDR_CTRL_ONE) begin
      mode_q <= i_wdata[2:0];
      age    <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end
  // Shadow of an all-zero interrupt mask
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) mask_zero <= 1'b1;
    else if (i_wr && i_addr == ADDR_IRQ_MASK) mask_zero <= (i_wdata[2:0] == 3'h0);
  end
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  chk_unmapped_read: assert property (i_rd && i_addr > ADDR_IRQ_MASK |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_ctrl_two_bits: assert property (i_rd && i_addr == ADDR_CTRL_TWO |=> (o_rdata & 16'hFFBF) == 16'h0000)
    else $error("control two has bits outside the flag");
  chk_ctrl_one_back: assert property (i_wr && i_addr == ADDR_CTRL_ONE ##1 i_rd && i_addr == ADDR_CTRL_ONE
    |=> o_rdata == $past(i_wdata, 2)) else $error("control one readback wrong");
  chk_off_quiet: assert property (mode_q == 3'h0 && age >= 4'h3 |-> !o_compare_out && !o_trig_clk)
    else $error("activity while disabled");
  chk_off_timer: assert property (i_rd && i_addr == ADDR_TIMER && mode_q == 3'h0 && age >= 4'h3
    |=> o_rdata == 16'h0000) else $error("timer moves while disabled");
  chk_trig_pulse: assert property (o_trig_clk |=> !o_trig_clk)
    else $error("trigger clock wider than one cycle");
  chk_event_pin: assert property (o_trig_clk && age >= 4'h4 && mode_q inside {[3'h1:3'h5]}
    |-> o_compare_out != $past(o_compare_out)) else $error("event without pin change");
  chk_irq_masked: assert property (mask_zero && $past(mask_zero) |-> !o_irq)
    else $error("interrupt while masked");
  cover property (o_trig_clk && mode_q == 3'h6);
  cover property ($rose(o_compare_out) && mode_q == 3'h5);
  cover property (o_irq);
endmodule // ocm_checker

bind ocm_channel ocm_checker u_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_compare_out(o_compare_out),
  .o_trig_clk(o_trig_clk), .o_irq(o_irq));

// ### tb/ocm_channel_tb.sv
/*
  Self-checking bench for the output compare channel.
  Assumes the pin sink model and the bound port checker.
*/
`timescale 1ns/100ps
module ocm_channel_tb;
  import ocm_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst  = 1'b1;
  logic        i_wr       = 1'b0;
  logic        i_rd       = 1'b0;
  logic [3:0]  i_addr     = 4'h0;
  logic [15:0] i_wdata    = 16'h0000;
  logic [15:0] o_rdata;
  logic        o_compare_out, o_trig_clk, o_irq;
  int          hi, tg, pu, n_mismatch = 0, num_checks = 0, cyc = 0;
  ocm_channel dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_compare_out(o_compare_out), .o_trig_clk(o_trig_clk),
    .o_irq(o_irq));
  ocm_pin_sink u_sink (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_pin(o_compare_out),
    .i_trig(o_trig_clk), .o_hi(hi), .o_tg(tg), .o_pu(pu));
  // Clock and hang limit
  initial forever #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1; i_rd <= 1'b0; i_addr <= a; i_wdata <= d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_core_clk);
    i_rd <= 1'b1; i_wr <= 1'b0; i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      i_wr <= 1'b0; i_rd <= 1'b0;
    end
    #1;
  endtask
  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin n_mismatch++; $display("[ERR] %s exp=%h got=%h", nm, e, g); end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    num_checks++;
    if (g != e) begin n_mismatch++; $display("[ERR] %s exp=%0d got=%0d", nm, e, g); end
  endtask
  task automatic setup(input int per, input int pr, input int se);
    wr(ADDR_CTRL_ONE, 16'h0000); wr(ADDR_PERIOD, 16'(per)); wr(ADDR_PRIMARY, 16'(pr)); wr(ADDR_SECONDARY, 16'(se));
    idle(3);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] v;
    int per, pr, se, s_hi, s_tg, s_pu, e_hi, e_tg, e_pu;
    logic [15:0] exp_q[$];
    void'($urandom(36303));
    repeat (16) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(ADDR_CTRL_ONE, v); chk_reg("ctrl_one", RST_CTRL, v);
    rd(ADDR_PERIOD, v); chk_reg("period", RST_PERIOD, v);
    rd(4'h8, v); chk_reg("unmapped", 16'h0000, v);
    wr(ADDR_CTRL_ONE, 16'hA5F0); rd(ADDR_CTRL_ONE, v); chk_reg("ctrl_one", 16'hA5F0, v);
    // Plain registers read back in write order, random contents
    for (int a = 2; a < 5; a++) begin
      exp_q.push_back(16'($urandom));
      wr(4'(a), exp_q[$]);
    end
    for (int a = 2; a < 5; a++) begin
      rd(4'(a), v);
      chk_reg("value_reg", exp_q.pop_front(), v);
    end
    $display("test registers done");
    // Every mode against counts from the pin model
    for (int m = 0; m < 8; m++) begin
      per = 20 + $urandom % 8; pr = 3 + $urandom % 7; se = 11 + $urandom % 7;
      setup(per, pr, se);
      s_hi = hi; s_tg = tg; s_pu = pu;
      wr(ADDR_CTRL_ONE, 16'(m));
      if (m == 3 || m >= 5) begin
        idle(per + 5);
        s_hi = hi; s_tg = tg; s_pu = pu;
        idle(2 * (per + 1));
      end else idle(3 * (per + 1));
      case (m)
        0: begin e_tg = 0; e_pu = 0; e_hi = 0; end
        1: begin e_tg = 1; e_pu = 1; e_hi = -1; end
        2: begin e_tg = 2; e_pu = 1; e_hi = -1; end
        3: begin e_tg = 2; e_pu = 2; e_hi = per + 1; end
        4: begin e_tg = 2; e_pu = 1; e_hi = se - pr; end
        5: begin e_tg = 4; e_pu = 2; e_hi = 2 * (se - pr); end
        6: begin e_tg = 4; e_pu = 2; e_hi = 2 * pr; end
        default: begin e_tg = 4; e_pu = 2; e_hi = 2 * (se - pr); end
      endcase
      chk_cnt("pin_edges", e_tg, tg - s_tg);
      chk_cnt("trig_clks", e_pu, pu - s_pu);
      if (e_hi >= 0) chk_cnt("high_cycles", e_hi, hi - s_hi);
      if (m < 3 || m == 4) chk_reg("pin_end", {15'h0000, m == 1}, {15'h0000, o_compare_out});
      $display("test mode %0d done", m);
    end
    // Primary written mid-period: held to period end in PWM, direct otherwise
    for (int b = 0; b < 2; b++) begin
      setup(20, b ? 10 : 15, 16);
      wr(ADDR_CTRL_ONE, b ? 16'h0006 : 16'h0001);
      idle(b ? 26 : 5);
      s_hi = hi;
      wr(ADDR_PRIMARY, b ? 16'h0002 : 16'h0008);
      idle(b ? 41 : 9);
      chk_cnt("high_after_write", b ? 11 : 5, hi - s_hi);
      rd(ADDR_TIMER, v);
      chk_reg("timer_run", b ? 16'h0005 : 16'h000F, v);
      $display("test buffering %0d done", b);
    end
    // Trigger flag, hardware and software clearing
    for (int t = 0; t < 2; t++) begin
      setup(20, 5, 12);
      wr(ADDR_CTRL_TWO, 16'h0000);
      wr(ADDR_CTRL_ONE, t ? 16'h0009 : 16'h0001);
      idle(70);
      rd(ADDR_CTRL_TWO, v); chk_reg("trig_flag", t ? 16'h0000 : 16'h0040, v);
      if (t == 0) begin
        wr(ADDR_CTRL_TWO, 16'h0000); rd(ADDR_CTRL_TWO, v); chk_reg("trig_flag_sw", 16'h0000, v);
      end
    end
    $display("test trigger flag done");
    // Interrupt status, mask and clear
    rd(ADDR_IRQ_STATUS, v); chk_reg("irq_cmp", 16'h0001, v & 16'h0001);
    chk_reg("irq_off", 16'h0000, {15'h0000, o_irq});
    wr(ADDR_CTRL_ONE, 16'h0000); wr(ADDR_IRQ_MASK, 16'h0007); idle(3);
    chk_reg("irq_on", 16'h0001, {15'h0000, o_irq});
    rd(ADDR_TIMER, v); chk_reg("timer_off", 16'h0000, v);
    wr(ADDR_IRQ_STATUS, 16'h0007); idle(3);
    chk_reg("irq_clr", 16'h0000, {15'h0000, o_irq});
    rd(ADDR_IRQ_STATUS, v); chk_reg("irq_status", 16'h0000, v);
    $display("test interrupt done");
    close_out();
  end
endmodule // ocm_channel_tb
